// >>> rtl/ccce_exec.sv
// Execution of the conditional call and clear control bit instructions
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "ccce_cfg.svh"

// Functional notes
// RULE_01 - Taken call pushes address after both words and jumps to target.
// RULE_02 - All listed conditions are ANDed; call taken only if all hold. Code ORs zero and negative when both are wanted true.
// RULE_03 - Tests: sum against zero, carry, wrap flag, test flag, pin low.
// RULE_04 - Failed condition only steps PC past both words; stack untouched.
// RULE_05 - Taken call lasts 4 cycles, not taken 2; fetch stalls add more.
// RULE_06 - Two prefetched words after a taken call are discarded.
// RULE_07 - Branch pin and test flag cannot be tested in one call.
// RULE_08 - Clear bit steps PC then zeroes the chosen bit in one cycle.
// RULE_09 - Clearable: carry, ram cfg, sign ext, test, ext flag, irq mask, sat.
// RULE_10 - Decode BE4E carry, BE40 irq mask, BE4A test, BE4C ext flag.
// RULE_11 - Call condition lives in first word: group field plus flag tests.
module ccce_exec
  import ccce_pkg::*;
#(
  parameter int WORD_W = 16,
  parameter int SUM_W = 32
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Instruction words from the fetch pipeline
  input wire logic INSTR_VALID,
  input wire logic [WORD_W-1:0] INSTR_WORD,
  output logic INSTR_READY,
  // Datapath state
  input wire logic [SUM_W-1:0] MAIN_SUM_REGISTER,
  input wire logic BRANCH_INPUT_PIN,
  // Program flow
  output logic [WORD_W-1:0] PC,
  output logic FETCH_FLUSH,
  output logic STACK_PUSH,
  output logic [WORD_W-1:0] STACK_TOP,
  output logic EXT_FLAG_PIN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  // ==========================================================
  // Declarations
  ccce_state_type state;
  ccce_state_type next_state;
  logic [WORD_W-1:0] status_word_zero;
  logic [WORD_W-1:0] status_word_one;
  logic [WORD_W-1:0] call_word;
  logic [2:0] pin_sync;
  logic pin_level;
  logic word_take;
  logic is_call;
  logic clr_hit;
  logic call_taken;
  logic wb_req;
  logic wb_wr;
  logic [WORD_W-1:0] wb_mask;
  ccce_cond_type call_cond;
  ccce_flags_type flags;
  // Instruction events and next program counter
  logic [WORD_W-1:0] next_pc;
  logic first_word;
  logic jump_now;
  logic step_now;
  logic clr_now;

  // ==========================================================
  // Branch input pin synchroniser
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_sync <= `CCCE_PIN_SYNC_IDLE;
    end else begin
      pin_sync <= {pin_sync[1:0], BRANCH_INPUT_PIN};
    end
  end

  // Level moves only once second and third stages agree
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_level <= 1'b1;
    end else if (pin_sync[1] == pin_sync[2]) begin
      pin_level <= pin_sync[2];
    end
  end

  // ==========================================================
  // Decode
  assign word_take = INSTR_VALID && INSTR_READY;
  assign is_call = (INSTR_WORD[`CCCE_CALL_OP_HI:`CCCE_CALL_OP_LO] ==
                    `CCCE_CALL_OP); // RULE_11
  always_comb begin
    case (INSTR_WORD) // RULE_10
      `CCCE_CLR_CARRY, `CCCE_CLR_RAMCFG, `CCCE_CLR_IRQ_MASK,
      `CCCE_CLR_SATURATE, `CCCE_CLR_SIGN_EXT, `CCCE_CLR_TEST_FLAG,
      `CCCE_CLR_EXT_FLAG: clr_hit = 1'b1;
      default: clr_hit = 1'b0;
    endcase
  end

  // Condition field sits in the low ten bits of the first word
  assign call_cond =
    ccce_cond_type'(call_word[`CCCE_COND_HI:`CCCE_COND_LO]); // RULE_11

  // Flags seen by the evaluator; wrap flag comes from software load
  assign flags.sum_is_zero = (MAIN_SUM_REGISTER == '0);
  assign flags.sum_negative = MAIN_SUM_REGISTER[SUM_W-1];
  assign flags.carry = status_word_one[`CCCE_S1_CARRY];
  assign flags.arith_wrap_flag = status_word_zero[`CCCE_S0_ARITH_WRAP];
  assign flags.test_flag = status_word_one[`CCCE_S1_TEST_FLAG];
  assign flags.branch_input_pin_low = !pin_level;

  ccce_cond_eval ccce_cond_eval_i (
    .cond(call_cond),
    .flags(flags),
    .taken(call_taken)
  );

  // ==========================================================
  // Instruction events
  // Word one of a call, a clear bit or any other opcode
  assign first_word = state == CCCE_IDLE && word_take;
  // Target word with every listed condition true, except zero and negative both wanted, where either one passes
  assign jump_now = state == CCCE_TARGET && word_take && call_taken;
  // Target word with a failed condition
  assign step_now = state == CCCE_TARGET && word_take && !call_taken;
  // Clear bit opcode taken as a fresh instruction
  assign clr_now = first_word && clr_hit;

  // ==========================================================
  // Sequencer
  assign INSTR_READY = 1'b1;

  // Discard slots run on the clock whether or not fetch offers a word,
  // so only fetch stalls on the two call words add to the four cycles of a taken call
  always_comb begin
    next_state = state;
    case (state)
      CCCE_IDLE: begin
        if (word_take && is_call) begin
          next_state = CCCE_TARGET;
        end
      end
      CCCE_TARGET: begin
        if (word_take && call_taken) begin
          next_state = CCCE_DISCARD1; // RULE_05
        end else if (word_take) begin
          next_state = CCCE_IDLE; // RULE_04
        end
      end
      CCCE_DISCARD1: next_state = CCCE_DISCARD2; // RULE_06
      CCCE_DISCARD2: next_state = CCCE_IDLE; // RULE_05
      default: next_state = CCCE_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= CCCE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // First call word kept for evaluation against the target word
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      call_word <= '0;
    end else if (first_word && is_call) begin
      call_word <= INSTR_WORD;
    end
  end

  // ==========================================================
  // Program counter and stack
  // Words in the discard slots leave the counter alone
  always_comb begin
    next_pc = PC;
    if (jump_now) begin
      next_pc = INSTR_WORD; // RULE_01
    end else if (step_now) begin
      next_pc = PC + WORD_W'(1); // RULE_04
    end else if (first_word) begin
      next_pc = PC + WORD_W'(1); // RULE_08
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PC <= `CCCE_PC_RESET;
    end else begin
      PC <= next_pc;
    end
  end

  // PC still points at the target word here, so plus one is past both
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      STACK_PUSH <= 1'b0;
      STACK_TOP <= '0;
    end else begin
      STACK_PUSH <= jump_now;
      if (jump_now) begin
        STACK_TOP <= PC + WORD_W'(1); // RULE_01
      end
    end
  end

  // Flush tells fetch to drop its two prefetched words
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FETCH_FLUSH <= 1'b0;
    end else begin
      FETCH_FLUSH <= jump_now; // RULE_06
    end
  end

  // ==========================================================
  // Wishbone slave
  // Ack follows one cycle after the request and blocks a second take
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_req && WB_WE_I;
  assign wb_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WB_DAT_O <= '0;
    end else if (wb_req && !WB_WE_I) begin
      case (WB_ADR_I)
        `CCCE_ADR_STATUS0: WB_DAT_O <= {16'h0000, status_word_zero};
        `CCCE_ADR_STATUS1: WB_DAT_O <= {16'h0000, status_word_one};
        `CCCE_ADR_PC: WB_DAT_O <= {16'h0000, PC};
        `CCCE_ADR_STACK_TOP: WB_DAT_O <= {16'h0000, STACK_TOP};
        default: WB_DAT_O <= '0;
      endcase
    end
  end

  // ==========================================================
  // Status words: software load, then clear bit instruction on top
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      status_word_zero <= `CCCE_S0_RESET;
    end else begin
      if (wb_wr && WB_ADR_I == `CCCE_ADR_STATUS0) begin
        status_word_zero <= (status_word_zero & ~wb_mask) |
                            (WB_DAT_I[15:0] & wb_mask);
      end
      if (clr_now) begin
        case (INSTR_WORD) // RULE_09
          `CCCE_CLR_IRQ_MASK:
            status_word_zero[`CCCE_S0_GLOBAL_IRQ_MASK] <= 1'b0; // RULE_08
          `CCCE_CLR_SATURATE:
            status_word_zero[`CCCE_S0_SATURATE] <= 1'b0; // RULE_08
          default: ;
        endcase
      end
    end
  end

  // Status word one: same order, software load then clear bit
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      status_word_one <= `CCCE_S1_RESET;
    end else begin
      if (wb_wr && WB_ADR_I == `CCCE_ADR_STATUS1) begin
        status_word_one <= (status_word_one & ~wb_mask) |
                           (WB_DAT_I[15:0] & wb_mask);
      end
      if (clr_now) begin
        case (INSTR_WORD) // RULE_09
          `CCCE_CLR_CARRY:
            status_word_one[`CCCE_S1_CARRY] <= 1'b0; // RULE_08
          `CCCE_CLR_RAMCFG:
            status_word_one[`CCCE_S1_RAMCFG] <= 1'b0; // RULE_08
          `CCCE_CLR_SIGN_EXT:
            status_word_one[`CCCE_S1_SIGN_EXT] <= 1'b0; // RULE_08
          `CCCE_CLR_TEST_FLAG:
            status_word_one[`CCCE_S1_TEST_FLAG] <= 1'b0; // RULE_08
          `CCCE_CLR_EXT_FLAG:
            status_word_one[`CCCE_S1_EXT_FLAG] <= 1'b0; // RULE_08
          default: ;
        endcase
      end
    end
  end

  assign EXT_FLAG_PIN = status_word_one[`CCCE_S1_EXT_FLAG];

endmodule

// >>> rtl/ccce_cfg.svh
// Numeric constants for the conditional call and clear bit execution block
`ifndef CCCE_CFG_SVH
`define CCCE_CFG_SVH

// ============================================================
// Clock and timing
`define CCCE_CLK_HZ 100000000
`define CCCE_TAKEN_CYCLES 4
`define CCCE_NOT_TAKEN_CYCLES 2
`define CCCE_DISCARD_WORDS 2

// ============================================================
// Opcodes
`define CCCE_CALL_OP 6'h3A
`define CCCE_CALL_OP_HI 15
`define CCCE_CALL_OP_LO 10
`define CCCE_COND_HI 9
`define CCCE_COND_LO 0
`define CCCE_PIN_SYNC_IDLE 3'h7
`define CCCE_CLR_CARRY 16'hBE4E
`define CCCE_CLR_RAMCFG 16'hBE44
`define CCCE_CLR_IRQ_MASK 16'hBE40
`define CCCE_CLR_SATURATE 16'hBE42
`define CCCE_CLR_SIGN_EXT 16'hBE46
`define CCCE_CLR_TEST_FLAG 16'hBE4A
`define CCCE_CLR_EXT_FLAG 16'hBE4C

// ============================================================
// Condition group field codes
`define CCCE_TP_BIO 2'h0
`define CCCE_TP_TC_SET 2'h1
`define CCCE_TP_TC_CLEAR 2'h2
`define CCCE_TP_NONE 2'h3

// ============================================================
// Status word bit positions
`define CCCE_S0_GLOBAL_IRQ_MASK 9
`define CCCE_S0_SATURATE 11
`define CCCE_S0_ARITH_WRAP 12
`define CCCE_S1_EXT_FLAG 4
`define CCCE_S1_CARRY 9
`define CCCE_S1_SIGN_EXT 10
`define CCCE_S1_TEST_FLAG 11
`define CCCE_S1_RAMCFG 12

// ============================================================
// Reset values
`define CCCE_S0_RESET 16'h0200
`define CCCE_S1_RESET 16'h0410
`define CCCE_PC_RESET 16'h0000

// ============================================================
// Wishbone register byte addresses
`define CCCE_ADR_STATUS0 4'h0
`define CCCE_ADR_STATUS1 4'h4
`define CCCE_ADR_PC 4'h8
`define CCCE_ADR_STACK_TOP 4'hC

`endif

// >>> rtl/ccce_pkg.sv
// Types shared by the conditional call and clear bit execution block
package ccce_pkg;

  // ==========================================================
  // Condition selection carried in the first call word
  typedef struct packed {
    logic [1:0] condition_group_field;
    logic [3:0] flag_test_mask;
    logic [3:0] flag_test_value;
  } ccce_cond_type;

  // ==========================================================
  // Flags the condition evaluator looks at
  typedef struct packed {
    logic sum_is_zero;
    logic sum_negative;
    logic carry;
    logic arith_wrap_flag;
    logic test_flag;
    logic branch_input_pin_low;
  } ccce_flags_type;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    CCCE_IDLE = 2'b00,
    CCCE_TARGET = 2'b01,
    CCCE_DISCARD1 = 2'b10,
    CCCE_DISCARD2 = 2'b11
  } ccce_state_type;

endpackage

// >>> rtl/ccce_cond_eval.sv
// Condition evaluator for the conditional subroutine call
`timescale 1ns/10ps
module ccce_cond_eval
  import ccce_pkg::*;
(
  // Condition field and flags
  input wire ccce_cond_type cond,
  input wire ccce_flags_type flags,
  // Result
  output logic taken
);

  logic zm, lm, vm, cm;
  logic zv, lv, vv, cv;
  logic sum_ok, wrap_ok, carry_ok, group_ok;

  assign zm = cond.flag_test_mask[3];
  assign lm = cond.flag_test_mask[2];
  assign vm = cond.flag_test_mask[1];
  assign cm = cond.flag_test_mask[0];
  assign zv = cond.flag_test_value[3];
  assign lv = cond.flag_test_value[2];
  assign vv = cond.flag_test_value[1];
  assign cv = cond.flag_test_value[0];

  // Sum tests; zero and negative both wanted means less-or-equal
  always_comb begin
    if (zm && lm && zv && lv) begin
      sum_ok = flags.sum_is_zero | flags.sum_negative; // RULE_03
    end else begin
      sum_ok = (!zm || (flags.sum_is_zero == zv)) &&
               (!lm || (flags.sum_negative == lv)); // RULE_03
    end
  end

  assign wrap_ok = !vm || (flags.arith_wrap_flag == vv); // RULE_03
  assign carry_ok = !cm || (flags.carry == cv); // RULE_03

  // Pin and test flag share one field, so only one can be tested
  always_comb begin
    case (cond.condition_group_field) // RULE_07
      `CCCE_TP_BIO: group_ok = flags.branch_input_pin_low;
      `CCCE_TP_TC_SET: group_ok = flags.test_flag;
      `CCCE_TP_TC_CLEAR: group_ok = !flags.test_flag;
      default: group_ok = 1'b1;
    endcase
  end

  assign taken = sum_ok & wrap_ok & carry_ok & group_ok; // RULE_02

endmodule

// >>> test/ccce_exec_asserts.sv
// Port checker for the call and clear bit execution block
`timescale 1ns/10ps
`include "ccce_cfg.svh"
module ccce_exec_asserts #(
  parameter int WORD_W = 16,
  parameter int SUM_W = 32
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Program flow
  input wire logic INSTR_VALID,
  input wire logic [WORD_W-1:0] INSTR_WORD,
  input wire logic [WORD_W-1:0] PC,
  input wire logic FETCH_FLUSH,
  input wire logic STACK_PUSH,
  input wire logic [WORD_W-1:0] STACK_TOP,
  input wire logic EXT_FLAG_PIN,
  // Wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O
);
  logic tgt;
  logic pd;
  logic free;
  logic st;
  // ==========================================================
  // Word tracking: discard slots and pending call target
  assign free = !STACK_PUSH && !pd;
  assign st = INSTR_VALID && free && !tgt;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pd <= 1'b0;
    end else begin
      pd <= STACK_PUSH;
    end
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tgt <= 1'b0;
    end else if (INSTR_VALID && free) begin
      tgt <= !tgt && INSTR_WORD[`CCCE_CALL_OP_HI:`CCCE_CALL_OP_LO] ==
             `CCCE_CALL_OP;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  sequence s_discard;
    $stable(PC) [*2];
  endsequence
  a_flush_pair: assert property (
    (STACK_PUSH || FETCH_FLUSH) |-> (STACK_PUSH && FETCH_FLUSH))
    else $error("flush and push apart");
  a_push_single: assert property (
    STACK_PUSH |=> !STACK_PUSH) else $error("push too long");
  a_jump_target: assert property (
    STACK_PUSH |-> PC == $past(INSTR_WORD) && $past(tgt))
    else $error("jump not to target word");
  a_return_addr: assert property (
    STACK_PUSH |-> STACK_TOP == $past(PC) + 16'h0001)
    else $error("wrong return address");
  a_discard_hold: assert property (
    STACK_PUSH |=> s_discard) else $error("prefetched word ran");
  a_plain_step: assert property (
    st |=> PC == $past(PC) + 16'h0001) else $error("no single step");
  a_fall_through: assert property (
    tgt && INSTR_VALID && free |=> STACK_PUSH || PC == $past(PC) + 16'h0001)
    else $error("fall through wrong");
  a_stack_kept: assert property (
    !STACK_PUSH |-> $stable(STACK_TOP)) else $error("stack moved");
  a_idle_hold: assert property (
    !INSTR_VALID |=> $stable(PC)) else $error("pc moved in wait");
  a_ext_clear: assert property (
    st && INSTR_WORD == `CCCE_CLR_EXT_FLAG |=> !EXT_FLAG_PIN)
    else $error("ext flag not cleared");
  a_wb_answer: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  a_ack_single: assert property (
    WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
endmodule

bind ccce_exec ccce_exec_asserts #(.WORD_W(WORD_W), .SUM_W(SUM_W))
  ccce_exec_asserts_i (.REF_CLK(REF_CLK), .RST(RST),
  .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD), .PC(PC),
  .FETCH_FLUSH(FETCH_FLUSH), .STACK_PUSH(STACK_PUSH),
  .STACK_TOP(STACK_TOP), .EXT_FLAG_PIN(EXT_FLAG_PIN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));

// >>> test/ccce_fetch_model.sv
// Fetch pipeline and program memory model feeding instruction words
`timescale 1ns/10ps
module ccce_fetch_model (
  // Clock
  input wire logic clk,
  // Instruction words
  output logic instr_valid,
  output logic [15:0] instr_word
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
  end
  // Wait states: the word bus toggles while nothing is offered
  task automatic idle(input int n);
    repeat (n) begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
      @(posedge clk);
    end
  endtask
  task automatic send(input logic [15:0] w, input int gap);
    idle(gap);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
  endtask
endmodule

// >>> test/ccce_exec_tb.sv
// Self-checking bench for the call and clear bit execution block
`timescale 1ns/10ps
`include "ccce_cfg.svh"
module ccce_exec_tb;
  logic clk;
  logic rst = 1'b1;
  logic pin = 1'b1;
  logic [31:0] sum = 32'h0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic vld;
  logic [15:0] word;
  logic flush;
  logic ext;
  int err_count = 0;
  int tests_run = 0;
  int nfl = 0;
  logic [15:0] stk = 16'h0000;
  logic [15:0] d;
  logic [15:0] pc0;
  logic [15:0] ops [7] = '{16'hBE4E, 16'hBE44, 16'hBE40, 16'hBE42,
    16'hBE46, 16'hBE4A, 16'hBE4C};
  logic [16:0] bm [7] = '{17'h10200, 17'h11000, 17'h00200, 17'h00800,
    17'h10400, 17'h10800, 17'h10010};

  ccce_fetch_model ccce_fetch_model_i (.clk(clk), .instr_valid(vld),
    .instr_word(word));
  ccce_exec ccce_exec_i (.REF_CLK(clk), .RST(rst), .INSTR_VALID(vld),
    .INSTR_WORD(word), .INSTR_READY(), .MAIN_SUM_REGISTER(sum),
    .BRANCH_INPUT_PIN(pin), .PC(), .FETCH_FLUSH(flush), .STACK_PUSH(),
    .STACK_TOP(), .EXT_FLAG_PIN(ext), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack));

  // ==========================================================
  // Tasks
  task automatic end_sim;
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
      input logic [15:0] dw, output logic [15:0] dr);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, dw};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    dr = rdat[15:0];
    chk({15'h0000, ack}, 16'h0001);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // Call with two prefetched clear words behind it
  task automatic tcall(input logic [9:0] c, input logic [31:0] s,
      input logic [15:0] s1, input logic [1:0] vp, input logic e);
    logic [15:0] t;
    logic [15:0] r;
    int f0;
    t = {6'h2F, c};
    sum <= s;
    pin <= vp[0];
    wb(1'b1, 4'h0, {3'h0, vp[1], 12'h000}, r);
    wb(1'b1, 4'h4, s1 | 16'h0010, r);
    wb(1'b0, 4'h8, 16'h0000, pc0);
    f0 = nfl;
    ccce_fetch_model_i.send({`CCCE_CALL_OP, c}, 0);
    ccce_fetch_model_i.send(t, 1);
    ccce_fetch_model_i.send(16'hBE4E, 0);
    ccce_fetch_model_i.send(16'hBE4C, 0);
    ccce_fetch_model_i.idle(1);
    if (e)
      stk = pc0 + 16'h0002;
    wb(1'b0, 4'h8, 16'h0000, r);
    chk(r, e ? t : pc0 + 16'h0004);
    wb(1'b0, 4'hC, 16'h0000, r);
    chk(r, stk);
    wb(1'b0, 4'h4, 16'h0000, r);
    chk(r & 16'h0210, e ? (s1 & 16'h0200) | 16'h0010 : 16'h0000);
    chk(16'(nfl - f0), {15'h0000, e});
  endtask

  // ==========================================================
  // Clock, watchdog and flush counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
  always @(posedge clk) begin
    if (flush === 1'b1)
      nfl <= nfl + 1;
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 4'h0, 16'h0000, d);
    chk(d, 16'h0200);
    wb(1'b0, 4'h4, 16'h0000, d);
    chk(d, 16'h0410);
    chk({15'h0000, ext}, 16'h0001);
    wb(1'b1, 4'h2, 16'hFFFF, d);
    wb(1'b0, 4'h2, 16'h0000, d);
    chk(d, 16'h0000);
    wb(1'b1, 4'h8, 16'h1234, d);
    wb(1'b0, 4'h8, 16'h0000, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, 4'h0, 16'hFFFF, d);
      wb(1'b1, 4'h4, 16'hFFFF, d);
      wb(1'b0, 4'h8, 16'h0000, pc0);
      ccce_fetch_model_i.send(ops[i], 0);
      ccce_fetch_model_i.idle(1);
      wb(1'b0, 4'h8, 16'h0000, d);
      chk(d, pc0 + 16'h0001);
      wb(1'b0, 4'h0, 16'h0000, d);
      chk(d & 16'h1A00, 16'h1A00 & ~(bm[i][16] ? 16'h0 : bm[i][15:0]));
      wb(1'b0, 4'h4, 16'h0000, d);
      chk(d & 16'h1E10, 16'h1E10 & ~(bm[i][16] ? bm[i][15:0] : 16'h0));
    end
    chk({15'h0000, ext}, 16'h0000);
    tcall(10'h300, 32'h1, 16'h0, 2'h1, 1'b1);
    tcall(10'h388, 32'h0, 16'h0, 2'h1, 1'b1);
    tcall(10'h380, 32'h5, 16'h0, 2'h1, 1'b1);
    tcall(10'h380, 32'h0, 16'h0, 2'h1, 1'b0);
    tcall(10'h344, 32'h80000000, 16'h0, 2'h1, 1'b1);
    tcall(10'h3CC, 32'h0, 16'h0, 2'h1, 1'b1);
    tcall(10'h3CC, 32'h1, 16'h0, 2'h1, 1'b0);
    tcall(10'h3C0, 32'h1, 16'h0, 2'h1, 1'b1);
    tcall(10'h3C0, 32'h0, 16'h0, 2'h1, 1'b0);
    tcall(10'h340, 32'h0, 16'h0, 2'h1, 1'b1);
    tcall(10'h310, 32'h0, 16'h0, 2'h1, 1'b1);
    tcall(10'h311, 32'h0, 16'h0200, 2'h1, 1'b1);
    tcall(10'h320, 32'h0, 16'h0, 2'h1, 1'b1);
    tcall(10'h322, 32'h0, 16'h0, 2'h3, 1'b1);
    tcall(10'h000, 32'h0, 16'h0, 2'h0, 1'b1);
    tcall(10'h000, 32'h0, 16'h0, 2'h1, 1'b0);
    tcall(10'h100, 32'h0, 16'h0800, 2'h1, 1'b1);
    tcall(10'h200, 32'h0, 16'h0800, 2'h1, 1'b0);
    tcall(10'h3DD, 32'hFFFFFFFF, 16'h0200, 2'h1, 1'b1);
    tcall(10'h3DD, 32'hFFFFFFFF, 16'h0, 2'h1, 1'b0);
    end_sim();
  end
endmodule
